/* File: common/usec_timer_defines.vh */
// Purpose: Register map, field positions and reset values of the microsecond timer.
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, one word per register.
// Notes: Definitions only.
`ifndef USEC_TIMER_DEFINES_VH
`define USEC_TIMER_DEFINES_VH

// ==========================================================================
// Register byte offsets
// ==========================================================================
`define OFS_TIME_SET_HIGH 7'h00
`define OFS_TIME_SET_LOW 7'h04
`define OFS_TIME_LATCHED_HIGH 7'h08
`define OFS_TIME_LATCHED_LOW 7'h0C
`define OFS_COMPARE_TARGET_0 7'h10
`define OFS_COMPARE_TARGET_1 7'h14
`define OFS_COMPARE_TARGET_2 7'h18
`define OFS_COMPARE_TARGET_3 7'h1C
`define OFS_ARMED_FLAGS 7'h20
`define OFS_TIME_LIVE_HIGH 7'h24
`define OFS_TIME_LIVE_LOW 7'h28
`define OFS_DEBUG_HALT_SELECT 7'h2C
`define OFS_SOFTWARE_HALT 7'h30
`define OFS_IRQ_RAW 7'h34
`define OFS_IRQ_ENABLE 7'h38
`define OFS_IRQ_FORCE 7'h3C
`define OFS_IRQ_MASKED_STATUS 7'h40

// ==========================================================================
// Fields and reset values
// ==========================================================================
`define BIT_SOFTWARE_HALT 0
`define BIT_HALT_ON_CPU_ZERO_DEBUG 1
`define BIT_HALT_ON_CPU_ONE_DEBUG 2
`define RST_TIME 64'h0000000000000000
`define RST_WORD 32'h00000000
`define RST_FLAGS 4'h0
`define RST_DEBUG_HALT 2'h3
`define UNMAPPED_READ 32'h00000000

`endif

/* File: logic/alarm_compare.v */
// Purpose: One compare alarm: target register, armed flag and fire pulse.
// Assumes: Write strobes come from the register decoder on the same clock.
// Notes: Firing and disarming share one flag; a write that arms wins.
`timescale 1ns/1ps
`include "usec_timer_defines.vh"

module alarm_compare (
    input wire mclk, // System clock.
    input wire sys_rst, // Synchronous reset, active high.
    input wire target_write, // One-cycle strobe writing the target.
    input wire [31:0] write_data, // Target value to store.
    input wire disarm, // One-cycle strobe disarming without firing.
    input wire [31:0] count_low, // Lower word of the live count.
    output reg [31:0] target, // Stored compare target.
    output reg armed, // Alarm is armed.
    output wire fire // One-cycle pulse when the alarm fires.
);

    // Fires in any cycle the armed target matches, even if the count is halted.
    assign fire = armed && (target == count_low);

    always @(posedge mclk) begin
        if (sys_rst) begin
            target <= `RST_WORD;
            armed <= 1'b0;
        end else if (target_write) begin
            target <= write_data;
            armed <= 1'b1;
        end else if (disarm || fire) begin
            armed <= 1'b0;
        end
    end

endmodule // alarm_compare

/* File: logic/usec_timer.v */
// Purpose: 64-bit microsecond time counter with four compare alarms on Avalon-MM.
// Assumes: tick is a one-cycle pulse on mclk from an external tick generator.
// Notes: Registers answer with one wait state; outputs come from flip-flops.
//
// Notes on behaviour
// - 64-bit count, two words, resets zero.
// - Low set word staged; high commits all.
// - Raw words read live, no side effects.
// - Four RW alarm targets, reset zero.
// - Target write stores and arms alarm.
// - Armed alarm fires on low-word match.
// - Firing disarms and sets raw interrupt.
// - Armed flags; write ones to disarm.
// - Software halt bit stops the count.
// - Debug halt per processor, reset one.
// - Status is raw and enable, or force.
// - Count advances one per reference tick.
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "usec_timer_defines.vh"

module usec_timer #(
    parameter ALARMS = 4 // Number of compare alarms.
) (
    input wire mclk, // System clock, 40 MHz.
    input wire sys_rst, // Synchronous reset, active high.
    input wire tick, // Reference tick pulse, same clock domain.
    input wire cpu0_debug, // Processor 0 in debug mode, asynchronous.
    input wire cpu1_debug, // Processor 1 in debug mode, asynchronous.
    input wire [6:0] avs_address, // Byte address.
    input wire avs_read, // Read request.
    input wire avs_write, // Write request.
    input wire [31:0] avs_writedata, // Write data.
    input wire [3:0] avs_byteenable, // Byte enables.
    output reg [31:0] avs_readdata, // Read data.
    output reg avs_waitrequest, // Wait request.
    output reg [1:0] avs_response, // Response code, always OKAY.
    output reg [3:0] alarm_irq, // Per-alarm interrupt lines.
    output reg irq // Combined interrupt line.
);

    // ======================================================================
    // State
    // ======================================================================
    reg [63:0] count;
    reg [31:0] staged_low;
    reg [31:0] latched_high;
    reg [1:0] debug_halt_select;
    reg software_halt;
    reg [3:0] irq_raw;
    reg [3:0] irq_enable;
    reg [3:0] irq_force;
    reg [1:0] dbg_meta;
    reg [1:0] dbg_sync;
    reg accept;
    reg [31:0] next_readdata;
    wire [31:0] compare_target_0;
    wire [31:0] compare_target_1;
    wire [31:0] compare_target_2;
    wire [31:0] compare_target_3;
    wire [3:0] armed;
    wire [3:0] fire;
    wire [3:0] status;
    wire halted;
    wire wr;
    wire rd;
    wire wr_set_low;
    wire wr_set_high;
    wire [3:0] wr_target;
    wire wr_armed;
    wire wr_debug_halt;
    wire wr_software_halt;
    wire wr_irq_raw;
    wire wr_irq_enable;
    wire wr_irq_force;
    wire latch_sample;
    wire [3:0] disarm;
    wire [31:0] merged_target_0;
    wire [31:0] merged_target_1;
    wire [31:0] merged_target_2;
    wire [31:0] merged_target_3;
    reg [3:0] next_irq_raw;

    // Merges enabled bytes of a write over the current value.
    function [31:0] merge;
        input [31:0] old_value;
        input [31:0] new_value;
        input [3:0] lanes;
        integer i;
        begin
            merge = old_value;
            for (i = 0; i < 4; i = i + 1) begin
                if (lanes[i]) begin
                    merge[i*8 +: 8] = new_value[i*8 +: 8];
                end
            end
        end
    endfunction

    // Decodes a register offset into a strobe.
    function hit;
        input [6:0] addr;
        input [6:0] offset;
        begin
            hit = (addr == offset);
        end
    endfunction

    // ======================================================================
    // Bus handshake
    // ======================================================================
    // A request is taken on the second edge it is seen; waitrequest drops for that edge.
    always @(posedge mclk) begin
        if (sys_rst) begin
            accept <= 1'b0;
            avs_waitrequest <= 1'b1;
        end else begin
            accept <= (avs_read || avs_write) && !accept;
            avs_waitrequest <= !((avs_read || avs_write) && !accept);
        end
    end

    assign wr = avs_write && accept;
    assign rd = avs_read && accept;

    // ======================================================================
    // Register decode
    // ======================================================================
    // The narrow words keep every field in byte lane 0, so only that lane writes them.
    assign wr_set_low = wr && hit(avs_address, `OFS_TIME_SET_LOW);
    assign wr_set_high = wr && hit(avs_address, `OFS_TIME_SET_HIGH);
    assign wr_target[0] = wr && hit(avs_address, `OFS_COMPARE_TARGET_0);
    assign wr_target[1] = wr && hit(avs_address, `OFS_COMPARE_TARGET_1);
    assign wr_target[2] = wr && hit(avs_address, `OFS_COMPARE_TARGET_2);
    assign wr_target[3] = wr && hit(avs_address, `OFS_COMPARE_TARGET_3);
    assign wr_armed = wr && hit(avs_address, `OFS_ARMED_FLAGS) && avs_byteenable[0];
    assign wr_debug_halt = wr && hit(avs_address, `OFS_DEBUG_HALT_SELECT) && avs_byteenable[0];
    assign wr_software_halt = wr && hit(avs_address, `OFS_SOFTWARE_HALT) && avs_byteenable[0];
    assign wr_irq_raw = wr && hit(avs_address, `OFS_IRQ_RAW) && avs_byteenable[0];
    assign wr_irq_enable = wr && hit(avs_address, `OFS_IRQ_ENABLE) && avs_byteenable[0];
    assign wr_irq_force = wr && hit(avs_address, `OFS_IRQ_FORCE) && avs_byteenable[0];

    // The upper half is caught on the edge that registers the lower read data, so a
    // carry between the two edges of one transfer cannot split the pair.
    assign latch_sample = avs_read && !accept
        && hit(avs_address, `OFS_TIME_LATCHED_LOW);

    // Ones written to the armed word disarm the matching alarms without firing.
    assign disarm = wr_armed ? avs_writedata[3:0] : `RST_FLAGS;

    // Each target write merges the enabled byte lanes over the stored target.
    assign merged_target_0 = merge(compare_target_0, avs_writedata, avs_byteenable);
    assign merged_target_1 = merge(compare_target_1, avs_writedata, avs_byteenable);
    assign merged_target_2 = merge(compare_target_2, avs_writedata, avs_byteenable);
    assign merged_target_3 = merge(compare_target_3, avs_writedata, avs_byteenable);

    // ======================================================================
    // Debug synchroniser and count
    // ======================================================================
    always @(posedge mclk) begin
        if (sys_rst) begin
            dbg_meta <= 2'h0;
            dbg_sync <= 2'h0;
        end else begin
            dbg_meta <= {cpu1_debug, cpu0_debug};
            dbg_sync <= dbg_meta;
        end
    end

    assign halted = software_halt
        || (dbg_sync[1] && debug_halt_select[1])
        || (dbg_sync[0] && debug_halt_select[0]);

    always @(posedge mclk) begin
        if (sys_rst) begin
            count <= `RST_TIME;
            staged_low <= `RST_WORD;
        end else begin
            if (wr_set_low) begin
                staged_low <= merge(staged_low, avs_writedata, avs_byteenable);
            end
            if (wr_set_high) begin
                count <= {merge(count[63:32], avs_writedata, avs_byteenable), staged_low};
            end else if (tick && !halted) begin
                count <= count + 64'h0000000000000001;
            end
        end
    end

    // ======================================================================
    // Alarms
    // ======================================================================
    alarm_compare u_compare_target_0 (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .target_write(wr_target[0]),
        .write_data(merged_target_0),
        .disarm(disarm[0]),
        .count_low(count[31:0]),
        .target(compare_target_0),
        .armed(armed[0]),
        .fire(fire[0])
    );

    alarm_compare u_compare_target_1 (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .target_write(wr_target[1]),
        .write_data(merged_target_1),
        .disarm(disarm[1]),
        .count_low(count[31:0]),
        .target(compare_target_1),
        .armed(armed[1]),
        .fire(fire[1])
    );

    alarm_compare u_compare_target_2 (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .target_write(wr_target[2]),
        .write_data(merged_target_2),
        .disarm(disarm[2]),
        .count_low(count[31:0]),
        .target(compare_target_2),
        .armed(armed[2]),
        .fire(fire[2])
    );

    alarm_compare u_compare_target_3 (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .target_write(wr_target[3]),
        .write_data(merged_target_3),
        .disarm(disarm[3]),
        .count_low(count[31:0]),
        .target(compare_target_3),
        .armed(armed[3]),
        .fire(fire[3])
    );

    // ======================================================================
    // Control and interrupt registers
    // ======================================================================
    assign status = (irq_raw & irq_enable) | irq_force;

    // A fire in the clearing cycle keeps its raw bit set.
    always @* begin
        next_irq_raw = irq_raw | fire;
        if (wr_irq_raw) begin
            next_irq_raw = (irq_raw & ~avs_writedata[3:0]) | fire;
        end
    end

    always @(posedge mclk) begin
        if (sys_rst) begin
            debug_halt_select <= `RST_DEBUG_HALT;
            software_halt <= 1'b0;
            irq_raw <= `RST_FLAGS;
            irq_enable <= `RST_FLAGS;
            irq_force <= `RST_FLAGS;
        end else begin
            if (wr_debug_halt) begin
                debug_halt_select <= {avs_writedata[`BIT_HALT_ON_CPU_ONE_DEBUG],
                    avs_writedata[`BIT_HALT_ON_CPU_ZERO_DEBUG]};
            end
            if (wr_software_halt) begin
                software_halt <= avs_writedata[`BIT_SOFTWARE_HALT];
            end
            if (wr_irq_enable) begin
                irq_enable <= avs_writedata[3:0];
            end
            if (wr_irq_force) begin
                irq_force <= avs_writedata[3:0];
            end
            irq_raw <= next_irq_raw;
        end
    end

    // ======================================================================
    // Latched read of the count
    // ======================================================================
    always @(posedge mclk) begin
        if (sys_rst) begin
            latched_high <= `RST_WORD;
        end else if (latch_sample) begin
            latched_high <= count[63:32];
        end
    end

    // ======================================================================
    // Interrupt outputs
    // ======================================================================
    // Both lines are registered, so they trail the status word by one edge.
    always @(posedge mclk) begin
        if (sys_rst) begin
            alarm_irq <= `RST_FLAGS;
            irq <= 1'b0;
        end else begin
            alarm_irq <= status;
            irq <= |status;
        end
    end

    // ======================================================================
    // Read mux
    // ======================================================================
    always @* begin
        case (avs_address)
            `OFS_TIME_LATCHED_HIGH: next_readdata = latched_high;
            `OFS_TIME_LATCHED_LOW: next_readdata = count[31:0];
            `OFS_COMPARE_TARGET_0: next_readdata = compare_target_0;
            `OFS_COMPARE_TARGET_1: next_readdata = compare_target_1;
            `OFS_COMPARE_TARGET_2: next_readdata = compare_target_2;
            `OFS_COMPARE_TARGET_3: next_readdata = compare_target_3;
            `OFS_ARMED_FLAGS: next_readdata = {28'h0000000, armed};
            `OFS_TIME_LIVE_HIGH: next_readdata = count[63:32];
            `OFS_TIME_LIVE_LOW: next_readdata = count[31:0];
            `OFS_DEBUG_HALT_SELECT: next_readdata = {29'h00000000, debug_halt_select, 1'b0};
            `OFS_SOFTWARE_HALT: next_readdata = {31'h00000000, software_halt};
            `OFS_IRQ_RAW: next_readdata = {28'h0000000, irq_raw};
            `OFS_IRQ_ENABLE: next_readdata = {28'h0000000, irq_enable};
            `OFS_IRQ_FORCE: next_readdata = {28'h0000000, irq_force};
            `OFS_IRQ_MASKED_STATUS: next_readdata = {28'h0000000, status};
            default: next_readdata = `UNMAPPED_READ;
        endcase
    end

    // Read data is registered on the first cycle and stands at the accepting edge.
    always @(posedge mclk) begin
        if (sys_rst) begin
            avs_readdata <= `RST_WORD;
            avs_response <= 2'h0;
        end else begin
            avs_readdata <= next_readdata;
            avs_response <= 2'h0;
        end
    end

endmodule // usec_timer

/* File: sim/usec_timer_props.sv */
// Purpose: Bus and interrupt properties of the microsecond timer.
// Assumes: Sees only the top module's ports.
// Notes: Bound to the timer at the foot of this file.
`timescale 1ns/1ps
module usec_timer_props #(
    parameter ALARMS = 4 // Number of alarms.
) (
    input wire mclk, // Clock.
    input wire sys_rst, // Reset.
    input wire tick, // Tick.
    input wire cpu0_debug, // Debug 0.
    input wire cpu1_debug, // Debug 1.
    input wire [6:0] avs_address, // Address.
    input wire avs_read, // Read.
    input wire avs_write, // Write.
    input wire [31:0] avs_writedata, // Write data.
    input wire [3:0] avs_byteenable, // Lanes.
    input wire [31:0] avs_readdata, // Read data.
    input wire avs_waitrequest, // Wait.
    input wire [1:0] avs_response, // Response.
    input wire [3:0] alarm_irq, // Alarm lines.
    input wire irq // Combined line.
);
    // ====
    // Properties
    default clocking @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    wire rd_ok = avs_read && !avs_waitrequest;
    wire wr_ok = avs_write && !avs_waitrequest;
    a_answer_two: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
        else $error("request not answered on time");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("wait low longer than one cycle");
    a_wait_needs_req: assert property (!avs_waitrequest |-> (avs_read || avs_write))
        else $error("wait low without request");
    a_resp_okay: assert property (avs_response == 2'h0)
        else $error("response not okay");
    a_reset_quiet: assert property ($past(sys_rst) |-> avs_waitrequest && alarm_irq == 4'h0)
        else $error("outputs not quiet after reset");
    a_irq_combined: assert property (irq == (|alarm_irq))
        else $error("combined line mismatch");
    a_force_line: assert property (wr_ok && avs_address == 7'h3C && avs_byteenable[0]
        && avs_writedata[3:0] == 4'hF |-> ##2 alarm_irq == 4'hF)
        else $error("forced lines not raised");
    a_status_view: assert property (rd_ok && avs_address == 7'h40 |->
        avs_readdata == {28'h0, alarm_irq})
        else $error("status word differs from lines");
    a_unmapped_zero: assert property (rd_ok && avs_address > 7'h40 |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    c_status_set: cover property (rd_ok && avs_address == 7'h40 && alarm_irq != 4'h0);
    c_force_write: cover property (wr_ok && avs_address == 7'h3C);
    c_irq_rise: cover property ($rose(irq));
endmodule // usec_timer_props
bind usec_timer usec_timer_props #(.ALARMS(ALARMS)) props_i (.mclk(mclk), .sys_rst(sys_rst),
    .tick(tick), .cpu0_debug(cpu0_debug), .cpu1_debug(cpu1_debug),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .alarm_irq(alarm_irq), .irq(irq));

/* File: sim/microsecond_timer_alarms_test.sv */
// Purpose: Self-checking bench of the microsecond timer.
// Assumes: Avalon-MM master tasks; tick driven by the bench.
// Notes: Table of register cases first, then count, alarm and halt cases.
`timescale 1ns/1ps
module microsecond_timer_alarms_test;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic tick = 1'b0;
    logic cpu0_debug = 1'b0;
    logic cpu1_debug = 1'b0;
    logic [6:0] avs_address = 7'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    wire [31:0] avs_readdata;
    wire avs_waitrequest;
    wire [1:0] avs_response;
    wire [3:0] alarm_irq;
    wire irq;
    int n_fail = 0;
    int tests_run = 0;
    logic [31:0] rd;
    logic [71:0] rows [0:16];
    always #12.5 mclk = ~mclk;
    usec_timer #(.ALARMS(4)) dut (.mclk(mclk), .sys_rst(sys_rst), .tick(tick),
        .cpu0_debug(cpu0_debug), .cpu1_debug(cpu1_debug), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .alarm_irq(alarm_irq), .irq(irq));
    // ====
    // Tasks
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Holds the request until waitrequest is sampled low, then releases it.
    task bus(input logic wr, input logic [6:0] a, input logic [31:0] d);
        int k;
        k = 0;
        avs_write <= wr;
        avs_read <= !wr;
        avs_address <= a;
        avs_writedata <= d;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0) begin
            k++;
            if (k > 20) begin
                n_fail++;
                tally_and_finish;
            end
            @(posedge mclk);
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge mclk);
    endtask
    task rdc(input logic [6:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk("register word", exp, rd);
    endtask
    task ticks(input int n);
        repeat (n) begin
            tick <= 1'b1;
            @(posedge mclk);
            tick <= 1'b0;
            @(posedge mclk);
        end
    endtask
    task reset_dut;
        sys_rst <= 1'b1;
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
    endtask
    // ====
    // Sequence
    initial begin
        rows = '{{1'b0, 7'h08, 32'h0, 32'h0}, {1'b0, 7'h0C, 32'h0, 32'h0},
            {1'b0, 7'h24, 32'h0, 32'h0}, {1'b0, 7'h28, 32'h0, 32'h0},
            {1'b0, 7'h10, 32'h0, 32'h0}, {1'b0, 7'h1C, 32'h0, 32'h0},
            {1'b0, 7'h20, 32'h0, 32'h0}, {1'b0, 7'h2C, 32'h0, 32'h6},
            {1'b0, 7'h30, 32'h0, 32'h0}, {1'b0, 7'h34, 32'h0, 32'h0},
            {1'b0, 7'h38, 32'h0, 32'h0}, {1'b0, 7'h3C, 32'h0, 32'h0},
            {1'b0, 7'h40, 32'h0, 32'h0}, {1'b0, 7'h44, 32'h0, 32'h0},
            {1'b1, 7'h2C, 32'h0, 32'h0}, {1'b1, 7'h38, 32'h5, 32'h5},
            {1'b1, 7'h30, 32'h1, 32'h1}};
        reset_dut;
        foreach (rows[i]) begin
            if (rows[i][71])
                bus(1'b1, rows[i][70:64], rows[i][63:32]);
            rdc(rows[i][70:64], rows[i][31:0]);
        end
        $display("test table done");
        ticks(5);
        rdc(7'h28, 32'h0);
        bus(1'b1, 7'h30, 32'h0);
        ticks(5);
        rdc(7'h28, 32'h5);
        $display("test count done");
        bus(1'b1, 7'h04, 32'hFFFFFFFF);
        rdc(7'h28, 32'h5);
        bus(1'b1, 7'h00, 32'h1);
        rdc(7'h28, 32'hFFFFFFFF);
        rdc(7'h24, 32'h1);
        rdc(7'h0C, 32'hFFFFFFFF);
        ticks(1);
        rdc(7'h08, 32'h1);
        rdc(7'h24, 32'h2);
        rdc(7'h08, 32'h1);
        rdc(7'h28, 32'h0);
        $display("test set and latch done");
        bus(1'b1, 7'h10, 32'h3);
        bus(1'b1, 7'h14, 32'h2);
        bus(1'b1, 7'h18, 32'h10);
        rdc(7'h20, 32'h7);
        rdc(7'h10, 32'h3);
        bus(1'b1, 7'h20, 32'h2);
        rdc(7'h20, 32'h5);
        ticks(3);
        rdc(7'h20, 32'h4);
        rdc(7'h34, 32'h1);
        rdc(7'h40, 32'h1);
        chk("alarm_irq", 32'h1, {28'h0, alarm_irq});
        chk("irq", 32'h1, {31'h0, irq});
        bus(1'b1, 7'h34, 32'h1);
        rdc(7'h34, 32'h0);
        chk("alarm_irq", 32'h0, {28'h0, alarm_irq});
        bus(1'b1, 7'h3C, 32'hF);
        rdc(7'h40, 32'hF);
        bus(1'b1, 7'h3C, 32'h0);
        $display("test alarms done");
        bus(1'b1, 7'h2C, 32'h4);
        cpu1_debug <= 1'b1;
        repeat (3) @(posedge mclk);
        ticks(2);
        rdc(7'h28, 32'h3);
        cpu1_debug <= 1'b0;
        cpu0_debug <= 1'b1;
        repeat (3) @(posedge mclk);
        ticks(1);
        rdc(7'h28, 32'h4);
        bus(1'b1, 7'h2C, 32'h2);
        ticks(1);
        rdc(7'h28, 32'h4);
        cpu0_debug <= 1'b0;
        $display("test debug halt done");
        reset_dut;
        rdc(7'h28, 32'h0);
        rdc(7'h2C, 32'h6);
        rdc(7'h20, 32'h0);
        avs_byteenable <= 4'h2;
        bus(1'b1, 7'h1C, 32'hFFFFABFF);
        avs_byteenable <= 4'hF;
        rdc(7'h1C, 32'h0000AB00);
        avs_byteenable <= 4'h2;
        bus(1'b1, 7'h20, 32'hFFFFFFFF);
        avs_byteenable <= 4'hF;
        rdc(7'h20, 32'h8);
        $display("test second reset done");
        tally_and_finish;
    end
endmodule // microsecond_timer_alarms_test
